/* hw/dpi_defines.vh */
`ifndef DPI_DEFINES_VH
`define DPI_DEFINES_VH
// ==========================================================================
// register byte offsets
`define DPI_OFS_OUT_IMG    8'h00
`define DPI_OFS_IN_IMG     8'h04
`define DPI_OFS_IO_STAT    8'h08
`define DPI_OFS_CTRL       8'h0C
`define DPI_OFS_SAFE       8'h10
`define DPI_OFS_DELAY      8'h14
`define DPI_OFS_EMCY_LO    8'h18
`define DPI_OFS_EMCY_HI    8'h1C
`define DPI_OFS_EMCY_STAT  8'h20
`define DPI_OFS_RESTORE    8'h24
`define DPI_OFS_WDOG       8'h28
// ==========================================================================
// control register fields
`define DPI_CTRL_DC_BIT    0
`define DPI_CTRL_KICK_BIT  1
// ==========================================================================
// reset values
`define DPI_SAFE_RST       16'h0000
`define DPI_WDOG_RST       16'h0FA0
`define DPI_IN_DLY_RST     8'h04
`define DPI_OUT_DLY_RST    8'h04
// ==========================================================================
// emergency codes
`define DPI_EC_CLEAR       16'h0000
`define DPI_EC_SUP_OC      16'h3001
`define DPI_EC_SUP_SURGE   16'h3002
`define DPI_EC_SUP_UV      16'h3003
`define DPI_EC_ACT_SURGE   16'h3004
`define DPI_EC_ACT_UV      16'h3005
`define DPI_EC_OVERTEMP    16'h4001
`define DPI_ER_SUPPLY_BIT  2
`define DPI_ER_TEMP_BIT    4
`define DPI_DIAG_TEMP      8'h06
`define DPI_RESTORE_KEY    32'h0000_0001
`endif

/* hw/dpi_process_image.v */
//
// Operation
// - inputs 1-16 in bytes 0,1 ascending
// - outputs 1-16 from bytes 0,1 ascending
// - output channel state mirrored into inputs
// - status byte 2 flags supply faults
// - emergency: code, error register, five diag bytes
// - fixed codes 3001-3005, 4001 with diag
// - emergency sent unsolicited, never acknowledged
// - emergency at fault onset and clearing, except sensor undervoltage
// - clearing message has code zero, bit cleared
// - clearing message keeps original diag data
// - two modes: sync-manager or sync0
// - default sync-manager mode, free running
// - dc mode outputs after output delay
// - dc mode samples after input delay
// - writing one requests defaults next power-up
// - timeout drives outputs to safe state
// - multi-byte data little-endian
`timescale 1ns/1ps
`include "dpi_defines.vh"
module dpi_process_image #(
  parameter WDOG_W = 16                   // width of timeout counter
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire [15:0] chan_pin_in,         // channel levels at the pins
  output reg  [15:0] chan_pin_out,        // channel drivers
  input  wire [5:0]  fault_pin,           // sc,surge,act oc,act uv,sens surge,sens uv
  input  wire        overtemp_pin,        // temperature fault level
  input  wire        sm_event,            // sync-manager event, same clock
  input  wire        sync0_event,         // sync0 strobe, same clock
  input  wire        frame_ok,            // valid frame received, same clock
  output reg         emcy_valid,          // emergency message available
  input  wire        emcy_ready,          // mailbox took the message
  output reg  [63:0] emcy_msg,            // message bytes, byte 0 lowest
  output reg         restore_defaults     // default request for next power-up
);
  // ========================================================================
  // pin synchronisers
  reg [15:0] chan_s1_r, chan_s2_r;
  reg [6:0]  flt_s1_r, flt_s2_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_s1_r <= 16'h0000;
      chan_s2_r <= 16'h0000;
      flt_s1_r  <= 7'h00;
      flt_s2_r  <= 7'h00;
    end else begin
      chan_s1_r <= chan_pin_in;
      chan_s2_r <= chan_s1_r;
      flt_s1_r  <= {overtemp_pin, fault_pin};
      flt_s2_r  <= flt_s1_r;
    end
  end

  // ========================================================================
  // ahb-lite slave, zero wait states
  reg        wr_pend_r;                   // write data phase pending
  reg [7:0]  wr_addr_r;                   // latched write offset
  reg [15:0] out_img_r;                   // master output image
  reg [15:0] in_img_r;                    // input image
  reg        dc_mode_r;                   // 0 = sync-manager mode
  reg [15:0] safe_r;                      // safe-state pattern
  reg [7:0]  in_dly_r, out_dly_r;         // sync0 delays in cycles
  reg [15:0] wdog_lim_r;                  // timeout in cycles
  reg [15:0] stat_r;                      // io status byte
  reg        timeout_r;                   // connection lost
  wire       acc = hsel & hready & htrans[1];
  wire       wr  = wr_pend_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // decode a byte offset against the latched address
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend_r <= acc & hwrite;
      if (acc)
        wr_addr_r <= haddr[7:0];
      if (acc & !hwrite) begin
        // read data registered into the data phase; unmapped reads zero
        case (haddr[7:0])
          `DPI_OFS_OUT_IMG:   hrdata <= {16'h0000, out_img_r};
          `DPI_OFS_IN_IMG:    hrdata <= {16'h0000, in_img_r};
          `DPI_OFS_IO_STAT:   hrdata <= {16'h0000, stat_r};
          `DPI_OFS_CTRL:      hrdata <= {31'h0000_0000, dc_mode_r};
          `DPI_OFS_SAFE:      hrdata <= {16'h0000, safe_r};
          `DPI_OFS_DELAY:     hrdata <= {16'h0000, out_dly_r, in_dly_r};
          `DPI_OFS_EMCY_LO:   hrdata <= emcy_msg[31:0];
          `DPI_OFS_EMCY_HI:   hrdata <= emcy_msg[63:32];
          `DPI_OFS_EMCY_STAT: hrdata <= {30'h0000_0000, timeout_r, emcy_valid};
          `DPI_OFS_RESTORE:   hrdata <= {31'h0000_0000, restore_defaults};
          `DPI_OFS_WDOG:      hrdata <= {16'h0000, wdog_lim_r};
          default:            hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ========================================================================
  // configuration registers
  reg kick_r;                             // software update strobe
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_img_r        <= 16'h0000;
      dc_mode_r        <= 1'b0;
      safe_r           <= `DPI_SAFE_RST;
      in_dly_r         <= `DPI_IN_DLY_RST;
      out_dly_r        <= `DPI_OUT_DLY_RST;
      wdog_lim_r       <= `DPI_WDOG_RST;
      restore_defaults <= 1'b0;
      kick_r           <= 1'b0;
    end else begin
      kick_r <= 1'b0;
      if (wr) begin
        if (hit(wr_addr_r, `DPI_OFS_OUT_IMG))
          out_img_r <= hwdata[15:0];
        if (hit(wr_addr_r, `DPI_OFS_CTRL)) begin
          dc_mode_r <= hwdata[`DPI_CTRL_DC_BIT];
          kick_r    <= hwdata[`DPI_CTRL_KICK_BIT];
        end
        if (hit(wr_addr_r, `DPI_OFS_SAFE))
          safe_r <= hwdata[15:0];
        if (hit(wr_addr_r, `DPI_OFS_DELAY)) begin
          in_dly_r  <= hwdata[7:0];
          out_dly_r <= hwdata[15:8];
        end
        if (hit(wr_addr_r, `DPI_OFS_WDOG))
          wdog_lim_r <= hwdata[15:0];
        // only the key value arms it; flag survives until power cycle
        if (hit(wr_addr_r, `DPI_OFS_RESTORE) && hwdata == `DPI_RESTORE_KEY)
          restore_defaults <= 1'b1;
      end
    end
  end

  // ========================================================================
  // connection watchdog
  reg [WDOG_W-1:0] wdog_cnt_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdog_cnt_r <= {WDOG_W{1'b0}};
      timeout_r  <= 1'b0;
    end else if (frame_ok) begin
      wdog_cnt_r <= {WDOG_W{1'b0}};
      timeout_r  <= 1'b0;
    end else if (wdog_cnt_r >= wdog_lim_r) begin
      timeout_r <= 1'b1;
    end else begin
      wdog_cnt_r <= wdog_cnt_r + 1'b1;
    end
  end

  // ========================================================================
  // update timing: free running or delayed after sync0
  reg [7:0] in_cnt_r, out_cnt_r;          // delay counters, tick fires at zero while armed
  reg       in_arm_r, out_arm_r;
  wire      in_tick  = dc_mode_r ? (in_arm_r && in_cnt_r == 8'h00) : 1'b1;
  wire      out_tick = dc_mode_r ? (out_arm_r && out_cnt_r == 8'h00)
                                 : (sm_event | kick_r | 1'b1);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_cnt_r  <= 8'h00;
      out_cnt_r <= 8'h00;
      in_arm_r  <= 1'b0;
      out_arm_r <= 1'b0;
    end else if (dc_mode_r && sync0_event) begin
      in_cnt_r  <= in_dly_r;
      out_cnt_r <= out_dly_r;
      in_arm_r  <= 1'b1;
      out_arm_r <= 1'b1;
    end else begin
      if (in_cnt_r != 8'h00)
        in_cnt_r <= in_cnt_r - 8'h01;
      else
        in_arm_r <= 1'b0;
      if (out_cnt_r != 8'h00)
        out_cnt_r <= out_cnt_r - 8'h01;
      else
        out_arm_r <= 1'b0;
    end
  end

  // ========================================================================
  // channel drive and input image
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_pin_out <= 16'h0000;
      in_img_r     <= 16'h0000;
    end else begin
      if (timeout_r)
        chan_pin_out <= safe_r;
      else if (out_tick)
        chan_pin_out <= out_img_r;
      // pin level covers both roles, so outputs read back too
      if (in_tick)
        in_img_r <= chan_s2_r;
    end
  end

  // ========================================================================
  // io status, live fault levels
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      stat_r <= 16'h0000;
    else
      stat_r <= {10'h000, flt_s2_r[5:0]};
  end

  // ========================================================================
  // emergency generator: one message per edge of each reported fault
  reg  [6:0] flt_seen_r;                  // level already reported
  reg  [6:0] pend_r;                      // edges still to report
  reg  [2:0] sel;
  reg        any;
  integer    i;
  // sensor undervoltage (index 5) has no emergency code of its own, so it
  // stays a status bit only; reporting it would reuse the overtemp code
  wire [6:0] chg = (flt_s2_r ^ flt_seen_r) & 7'h5F;

  // priority pick of lowest pending fault
  always @* begin
    sel = 3'd0;
    any = 1'b0;
    for (i = 6; i >= 0; i = i - 1)
      if (pend_r[i]) begin
        sel = i[2:0];
        any = 1'b1;
      end
  end

  // map fault index to code, onset or clear
  function [15:0] code_of;
    input [2:0] s;
    input       rise;
    begin
      case (s)
        3'd0:    code_of = `DPI_EC_SUP_OC;
        3'd1:    code_of = `DPI_EC_SUP_SURGE;
        3'd2:    code_of = `DPI_EC_SUP_UV;
        3'd3:    code_of = `DPI_EC_ACT_SURGE;
        3'd4:    code_of = `DPI_EC_ACT_UV;
        default: code_of = `DPI_EC_OVERTEMP;
      endcase
      if (!rise)
        code_of = `DPI_EC_CLEAR;
    end
  endfunction

  reg  [7:0] err_reg_r;                   // running error register
  wire       rise_now = flt_seen_r[sel] ^ 1'b1;
  wire [7:0] diag1  = (sel >= 3'd5) ? `DPI_DIAG_TEMP : {5'h00, sel + 3'd1};
  // supply bit toggled by this message, and supply levels after it
  wire [5:0] sup_hit   = (sel <= 3'd5) ? (6'h01 << sel) : 6'h00;
  wire [5:0] sup_after = flt_seen_r[5:0] ^ sup_hit;
  wire       ebit_sup  = |sup_after;
  wire       ebit_tmp = (sel == 3'd6) ? rise_now : flt_seen_r[6];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flt_seen_r <= 7'h00;
      pend_r     <= 7'h00;
      err_reg_r  <= 8'h00;
      emcy_valid <= 1'b0;
      emcy_msg   <= 64'h0000_0000_0000_0000;
    end else begin
      pend_r <= pend_r | chg;
      if (emcy_valid && emcy_ready)
        emcy_valid <= 1'b0;
      else if (!emcy_valid && any) begin
        flt_seen_r[sel] <= rise_now;
        pend_r[sel]     <= chg[sel] & 1'b0;
        err_reg_r[`DPI_ER_SUPPLY_BIT] <= ebit_sup;
        err_reg_r[`DPI_ER_TEMP_BIT]   <= ebit_tmp;
        // byte order low first: code lsb, code msb, err, diag 0..4
        emcy_msg <= {16'h0000, 8'h00, diag1, 8'h00,
                     {err_reg_r[7:5], ebit_tmp, err_reg_r[3], ebit_sup, err_reg_r[1:0]},
                     code_of(sel, rise_now)};
        emcy_valid <= 1'b1;
      end
    end
  end

endmodule // dpi_process_image

/* tb/dpi_process_image_properties.sv */
`timescale 1ns/1ps
module dpi_props (
  input wire        hclk,
  input wire        hresetn,
  input wire        overtemp_pin,
  input wire        emcy_valid,
  input wire        emcy_ready,
  input wire [63:0] emcy_msg,
  input wire        restore_defaults
);
  // ========================================================
  // one clock domain, one reset
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire [15:0] code = emcy_msg[15:0];  // error code field
  wire        ot   = code == 16'h4001; // overtemp message
  sequence s_ot_msg;
    emcy_valid && ot;
  endsequence
  sequence s_zero_msg;
    emcy_valid && code == 16'h0000;
  endsequence
  // ========================================================
  // message framing and content
  property p_hold;
    emcy_valid && !emcy_ready |=> emcy_valid && $stable(emcy_msg);
  endproperty
  property p_pad;
    emcy_valid |-> emcy_msg[31:24] == 8'h00 && emcy_msg[63:40] == 24'h00_0000;
  endproperty
  property p_reg;
    emcy_valid && code != 16'h0000 |-> emcy_msg[23:16] == (ot ? 8'h10 : 8'h04);
  endproperty
  property p_diag;
    emcy_valid && code != 16'h0000 |-> emcy_msg[39:32] == (ot ? 8'h06 : code[7:0]);
  endproperty
  property p_clr;
    s_zero_msg |-> emcy_msg[23:16] == 8'h00;
  endproperty
  // ========================================================
  // overtemp edges must be announced within a bound; restore request must stay set
  property p_onset;
    $rose(overtemp_pin) |-> ##[1:40] s_ot_msg;
  endproperty
  property p_offset;
    $fell(overtemp_pin) |-> ##[1:40] s_zero_msg;
  endproperty
  property p_sticky;
    restore_defaults |=> restore_defaults;
  endproperty
  a_hold:   assert property (p_hold)   else $error("message changed before taken");
  a_pad:    assert property (p_pad)    else $error("padding bytes not zero");
  a_reg:    assert property (p_reg)    else $error("error register wrong");
  a_diag:   assert property (p_diag)   else $error("diagnostic byte wrong");
  a_clr:    assert property (p_clr)    else $error("clear message register set");
  a_onset:  assert property (p_onset)  else $error("no onset message");
  a_offset: assert property (p_offset) else $error("no clearing message");
  a_sticky: assert property (p_sticky) else $error("restore request dropped");
endmodule // dpi_props

bind dpi_process_image dpi_props u_props (.hclk, .hresetn, .overtemp_pin, .emcy_valid,
  .emcy_ready, .emcy_msg, .restore_defaults);

/* tb/dpi_fb_master.sv */
`timescale 1ns/1ps
module dpi_fb_master (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        run,        // frames keep arriving
  input  wire        slow,       // mailbox stalls three cycles
  output reg         sm_event,
  output reg         frame_ok,
  input  wire        emcy_valid,
  input  wire [63:0] emcy_msg,
  output wire        emcy_ready
);
  reg   [3:0]  cyc_r;  // frame cycle position
  reg   [1:0]  wait_r; // stall counter
  logic [63:0] log[$]; // messages taken
  // taken without any reply back to the device
  assign emcy_ready = emcy_valid && (!slow || wait_r == 2'd3);
  // ========================================================
  // frame pacing and mailbox capture
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_r    <= 4'h0;
      wait_r   <= 2'd0;
      sm_event <= 1'b0;
      frame_ok <= 1'b0;
    end else begin
      cyc_r    <= cyc_r + 4'h1;
      sm_event <= cyc_r[2:0] == 3'd7;
      frame_ok <= run && cyc_r == 4'hF;
      wait_r   <= (emcy_valid && !emcy_ready) ? wait_r + 2'd1 : 2'd0;
      if (emcy_valid && emcy_ready) log.push_back(emcy_msg);
    end
  end
endmodule // dpi_fb_master

/* tb/tb.sv */
`timescale 1ns/1ps
`include "dpi_defines.vh"
module tb;
  reg         hclk, hresetn, hsel, hwrite, overtemp_pin, sync0_event, run, slow;
  reg  [31:0] haddr, hwdata, rd;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize;
  reg  [5:0]  fault_pin;
  reg  [15:0] ext_in;  // levels from external sensors
  wire        hreadyout, hresp, sm_event, frame_ok, emcy_valid, emcy_ready;
  wire        restore_defaults;
  wire [31:0] hrdata;
  wire [15:0] chan_pin_out;
  wire [63:0] emcy_msg;
  integer     n_errors, samples_checked, ticks, k;
  // output channels read back their own level; sensor levels are ORed onto every channel
  wire [15:0] chan_pin_in = chan_pin_out | ext_in;
  dpi_process_image dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .chan_pin_in, .chan_pin_out,
    .fault_pin, .overtemp_pin, .sm_event, .sync0_event, .frame_ok, .emcy_valid,
    .emcy_ready, .emcy_msg, .restore_defaults);
  dpi_fb_master pm_u (.hclk, .hresetn, .run, .slow, .sm_event, .frame_ok, .emcy_valid,
    .emcy_msg, .emcy_ready);
  // ========================================================
  // shared tasks
  task chk(input [63:0] seen, input [63:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge hclk);
  endtask
  // single word transfer; read data lands in rd
  task ahb(input w, input [31:0] a, input [31:0] d);
    begin
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // ========================================================
  // scenarios
  task t_reset;
    begin
      ahb(0, `DPI_OFS_CTRL, 0);      chk(rd, 0);
      ahb(0, `DPI_OFS_DELAY, 0);     chk(rd, {`DPI_OUT_DLY_RST, `DPI_IN_DLY_RST});
      ahb(0, `DPI_OFS_IO_STAT, 0);   chk(rd, 0);
      ahb(0, 32'h0000_0040, 0);      chk(rd, 0);
      chk(hresp, 1'b0);
      $display("test reset done");
    end
  endtask
  task t_map;
    begin
      ext_in <= 16'hA500;
      ahb(1, `DPI_OFS_OUT_IMG, 32'h0000_00C3);
      cyc(12);
      chk(chan_pin_out, 16'h00C3);
      ahb(0, `DPI_OFS_IN_IMG, 0);
      chk(rd, 32'h0000_A5C3);
      $display("test map done");
    end
  endtask
  // sync0 mode: outputs after 3 cycles, inputs after 10
  task t_dc;
    begin
      ahb(1, `DPI_OFS_DELAY, 32'h0000_030A);
      ahb(1, `DPI_OFS_CTRL, 32'h0000_0001);
      ahb(1, `DPI_OFS_OUT_IMG, 32'h0000_1100);
      ext_in <= 16'h2200;
      cyc(20);
      chk(chan_pin_out, 16'h00C3);
      ahb(0, `DPI_OFS_IN_IMG, 0);   chk(rd, 32'h0000_A5C3);
      sync0_event <= 1'b1;
      @(posedge hclk);
      sync0_event <= 1'b0;
      cyc(2);
      chk(chan_pin_out, 16'h00C3);
      cyc(14);
      chk(chan_pin_out, 16'h1100);
      ahb(0, `DPI_OFS_IN_IMG, 0);   chk(rd, 32'h0000_3300);
      ahb(1, `DPI_OFS_CTRL, 0);
      $display("test dc done");
    end
  endtask
  task t_fault;
    begin
      for (k = 0; k < 6; k = k + 1) begin
        fault_pin <= 6'h01 << k;
        cyc(30);
        ahb(0, `DPI_OFS_IO_STAT, 0);   chk(rd, 32'h1 << k);
        fault_pin <= 6'h00;
        cyc(30);
        ahb(0, `DPI_OFS_IO_STAT, 0);   chk(rd, 0);
      end
      slow <= 1'b1;
      overtemp_pin <= 1'b1;
      cyc(30);
      overtemp_pin <= 1'b0;
      cyc(40);
      slow <= 1'b0;
      chk(pm_u.log.size(), 12);
      for (k = 0; k < 5; k = k + 1)
        chk(pm_u.log[2*k][39:0], {8'h01 + k[7:0], 8'h00, 8'h04, `DPI_EC_SUP_OC + k[15:0]});
      for (k = 1; k < pm_u.log.size(); k = k + 2) begin
        chk(pm_u.log[k][15:0], 16'h0000);
        chk(pm_u.log[k][39:16], {pm_u.log[k-1][39:24], 8'h00});
      end
      chk(pm_u.log[pm_u.log.size()-2][39:0], 40'h06_00_10_4001);
      ahb(0, `DPI_OFS_EMCY_HI, 0);   chk(rd, 32'h0000_0006);
      ahb(0, `DPI_OFS_EMCY_LO, 0);   chk(rd, 32'h0000_0000);
      $display("test fault done");
    end
  endtask
  task t_timeout;
    begin
      ahb(1, `DPI_OFS_SAFE, 32'h0000_5A5A);
      ahb(1, `DPI_OFS_WDOG, 32'h0000_0040);
      ahb(1, `DPI_OFS_OUT_IMG, 32'h0000_FFFF);
      run <= 1'b0;
      cyc(30);
      chk(chan_pin_out, 16'hFFFF);
      cyc(60);
      chk(chan_pin_out, 16'h5A5A);
      ahb(0, `DPI_OFS_EMCY_STAT, 0); chk(rd[1], 1'b1);
      run <= 1'b1;
      $display("test timeout done");
    end
  endtask
  task t_restore;
    begin
      ahb(1, `DPI_OFS_RESTORE, 32'h0000_0002);
      cyc(2);
      chk(restore_defaults, 0);
      ahb(1, `DPI_OFS_RESTORE, `DPI_RESTORE_KEY);
      cyc(2);
      chk(restore_defaults, 1);
      $display("test restore done");
    end
  endtask
  // ========================================================
  // clock, hang guard and main sequence
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  initial begin
    {n_errors, samples_checked, ticks} = 0;
    {hresetn, hwrite, overtemp_pin, sync0_event, slow} = 0;
    {haddr, hwdata, htrans, fault_pin, ext_in} = 0;
    hsel = 1'b1;
    run = 1'b1;
    hsize = 3'b010;
    cyc(2);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_map;
    t_dc;
    t_fault;
    t_timeout;
    t_restore;
    report_and_stop;
  end
endmodule // tb
